// ==== design/lpdp_datapath.sv ====
// LPDDR3 user-side data path with periodic read injection
// Operation
// - Eight beats per lane form one 64-bit slice, first beat lowest.
// - Lane N occupies payload bits N*64 upward; bit0 beat0 is bit0.
// - Read payload uses the same beat and lane order as writes.
// - Mask bit of lane N gathered per beat into mask bits N*8 upward.
// - Reads return in request order, payload valid only with valid strobe.
// - Read-last marks the final payload cycle of each read burst.
// - Two consecutive DRAM reads issued at least every microsecond.
// - Injected reads during writes target next queued request address.
// - Injected reads when idle use the last accessed address.
// - Activate the row before injected reads if it is closed.
// - Injected reads use the normal command issue path.
// - Injected read data is dropped, never shown to the requester.
// - Command accept stays low while a periodic read is inserted.
// - Write payload taken only when strobe and buffer ready both high.
// - User clock runs at a quarter of the memory clock.
`timescale 1ns/10ps
`include "lpdp_map.svh"
module lpdp_datapath
    import lpdp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Application command side
    input wire logic app_en,
    input wire logic [2:0] app_cmd,
    input wire logic [`LPDP_ADDR_W-1:0] app_addr,
    output logic app_rdy,
    // Application write side
    input wire logic [`LPDP_DATA_W-1:0] app_wdf_data,
    input wire logic [`LPDP_MASK_W-1:0] app_wdf_mask,
    input wire logic app_wdf_wren,
    input wire logic app_wdf_end,
    output logic app_wdf_rdy,
    // Application read side
    output logic [`LPDP_DATA_W-1:0] app_rd_data,
    output logic app_rd_data_valid,
    output logic app_rd_data_end,
    // Memory command side toward the scheduler
    output logic mem_cmd_valid,
    output logic [2:0] mem_cmd,
    output logic mem_cmd_act,
    output logic [`LPDP_ADDR_W-1:0] mem_cmd_addr,
    input wire logic mem_cmd_ready,
    input wire logic mem_row_open,
    // Eight beats per user cycle, memory clock four times faster
    output logic [`LPDP_BEATS*`LPDP_LANES*`LPDP_LANE_W-1:0] memory_data_lines,
    output logic [`LPDP_BEATS*`LPDP_LANES-1:0] memory_mask_lines,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    // Memory read beats with the injected flag echoed back by the scheduler
    input wire logic [`LPDP_BEATS*`LPDP_LANES*`LPDP_LANE_W-1:0] mem_rd_beats,
    input wire logic mem_rd_valid,
    input wire logic mem_rd_injected
);
    localparam int BW = `LPDP_LANES * `LPDP_LANE_W;
    localparam int FW = `LPDP_DATA_W + `LPDP_MASK_W;

    typedef struct packed {
        lpdp_inj_t inj;
        logic [`LPDP_CNT_W-1:0] cnt;
        logic [`LPDP_ADDR_W-1:0] last_addr;
        logic last_rd;
        logic [`LPDP_DATA_W-1:0] rd_data;
        logic rd_valid;
        logic rd_end;
        logic [`LPDP_BEATS*BW-1:0] wr_beats;
        logic [`LPDP_BEATS*`LPDP_LANES-1:0] wr_mask;
        logic wr_valid;
    } lpdp_st_t;
    lpdp_st_t st;
    lpdp_st_t next_st;

    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FW-1:0] fifo_out_data;
    logic inj_busy;
    logic inj_due;
    logic rd_pair;
    logic [`LPDP_DATA_W-1:0] rd_packed;
    logic [`LPDP_DATA_W-1:0] wr_word;
    logic [`LPDP_MASK_W-1:0] wr_mword;
    logic [`LPDP_BEATS*BW-1:0] wr_unpacked;
    logic [`LPDP_BEATS*`LPDP_LANES-1:0] wr_munpacked;

    // Payload bit index of bit b of lane n at beat k
    function automatic int lpdp_bit(input int n, input int k, input int b);
        return n * `LPDP_SLICE_W + k * `LPDP_LANE_W + b;
    endfunction

    // Write payload FIFO: ready reaches the requester directly
    lpdp_fifo #(
        .WIDTH(FW),
        .DEPTH(`LPDP_FIFO_DEPTH),
        .PW(`LPDP_RDQ_PW)
    ) u_wfifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(app_wdf_wren),
        .in_ready(app_wdf_rdy),
        .in_data({app_wdf_mask, app_wdf_data}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );
    assign wr_word = fifo_out_data[`LPDP_DATA_W-1:0];
    assign wr_mword = fifo_out_data[FW-1:`LPDP_DATA_W];

    // Beat reorder between lane slices and wire beats
    genvar gn, gk, gb;
    generate
        for (gn = 0; gn < `LPDP_LANES; gn++) begin : g_lane
            for (gk = 0; gk < `LPDP_BEATS; gk++) begin : g_beat
                for (gb = 0; gb < `LPDP_LANE_W; gb++) begin : g_bit
                    assign wr_unpacked[gk*BW + gn*`LPDP_LANE_W + gb] =
                        wr_word[lpdp_bit(gn, gk, gb)];
                    assign rd_packed[lpdp_bit(gn, gk, gb)] =
                        mem_rd_beats[gk*BW + gn*`LPDP_LANE_W + gb];
                end
                assign wr_munpacked[gk*`LPDP_LANES + gn] =
                    wr_mword[gn*`LPDP_BEATS + gk];
            end
        end
    endgenerate

    // Injection blocks user commands while pending or in flight
    assign inj_due = (st.cnt == '0);
    assign inj_busy = (st.inj != LPDP_IDLE) || inj_due;
    assign app_rdy = mem_cmd_ready && !inj_busy;
    assign fifo_out_ready = !st.wr_valid || mem_wr_ready;

    // Shared command port keeps injected reads in normal issue order
    always_comb begin
        mem_cmd_valid = 1'b0;
        mem_cmd = app_cmd;
        mem_cmd_act = 1'b0;
        mem_cmd_addr = app_addr;
        // Pending request address wins, else last accessed one
        if (app_en) begin
            mem_cmd_addr = app_addr;
        end else begin
            mem_cmd_addr = st.last_addr;
        end
        unique case (st.inj)
            LPDP_IDLE: begin
                mem_cmd_valid = app_en && !inj_due;
                mem_cmd_addr = app_addr;
            end
            LPDP_ACT: begin
                mem_cmd_valid = 1'b1;
                mem_cmd_act = 1'b1;
            end
            LPDP_RD0, LPDP_RD1: begin
                mem_cmd_valid = 1'b1;
                mem_cmd = `LPDP_CMD_READ;
            end
        endcase
    end

    assign rd_pair = clk_en && mem_cmd_valid && mem_cmd_ready && !mem_cmd_act &&
        mem_cmd == `LPDP_CMD_READ && st.last_rd;

    always_comb begin
        next_st = st;
        // Any back-to-back read pair restarts the interval
        if (rd_pair) begin
            next_st.cnt = `LPDP_CNT_W'(`LPDP_PERIOD_CYC);
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        if (mem_cmd_valid && mem_cmd_ready && !mem_cmd_act) begin
            next_st.last_rd = (mem_cmd == `LPDP_CMD_READ);
            next_st.last_addr = mem_cmd_addr;
        end else if (mem_cmd_valid && mem_cmd_ready) begin
            next_st.last_rd = 1'b0;
        end
        unique case (st.inj)
            LPDP_IDLE: begin
                if (inj_due && !rd_pair) begin
                    next_st.inj = mem_row_open ? LPDP_RD0 : LPDP_ACT;
                end
            end
            LPDP_ACT: begin
                if (mem_cmd_ready) begin
                    next_st.inj = LPDP_RD0;
                end
            end
            LPDP_RD0: begin
                if (mem_cmd_ready) begin
                    next_st.inj = LPDP_RD1;
                end
            end
            LPDP_RD1: begin
                if (mem_cmd_ready) begin
                    next_st.inj = LPDP_IDLE;
                end
            end
        endcase
        // Write beats toward memory
        if (fifo_out_valid && fifo_out_ready) begin
            next_st.wr_beats = wr_unpacked;
            next_st.wr_mask = wr_munpacked;
            next_st.wr_valid = 1'b1;
        end else if (mem_wr_ready) begin
            next_st.wr_valid = 1'b0;
        end
        // Scheduler returns reads in issue order; injected ones dropped
        next_st.rd_valid = mem_rd_valid && !mem_rd_injected;
        next_st.rd_end = mem_rd_valid && !mem_rd_injected;
        if (mem_rd_valid && !mem_rd_injected) begin
            next_st.rd_data = rd_packed;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.inj <= LPDP_IDLE;
            st.cnt <= `LPDP_CNT_W'(`LPDP_PERIOD_CYC);
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign app_rd_data = st.rd_data;
    assign app_rd_data_valid = st.rd_valid;
    assign app_rd_data_end = st.rd_end;
    assign memory_data_lines = st.wr_beats;
    assign memory_mask_lines = st.wr_mask;
    assign mem_wr_valid = st.wr_valid;

    // One BL8 burst per command at 4:1 ratio: the last cycle is also the first
    property p_rdy_blocked;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.inj != LPDP_IDLE) |-> !app_rdy;
    endproperty
    a_rdy_blocked: assert property (p_rdy_blocked)
        else $error("accept during injection");

    property p_inj_dropped;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && mem_rd_valid && mem_rd_injected) |=> !app_rd_data_valid;
    endproperty
    a_inj_dropped: assert property (p_inj_dropped) else $error("injected data shown");

    property p_rd_valid;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && mem_rd_valid && !mem_rd_injected) |=> app_rd_data_valid && app_rd_data_end;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not returned");

    property p_end_with_valid;
        @(posedge sys_clk) disable iff (!rst_n)
        app_rd_data_end |-> app_rd_data_valid;
    endproperty
    a_end_with_valid: assert property (p_end_with_valid)
        else $error("end without valid");

    sequence s_rd0;
        st.inj == LPDP_RD0 && mem_cmd_ready && clk_en;
    endsequence
    property p_pair;
        @(posedge sys_clk) disable iff (!rst_n)
        s_rd0 |=> st.inj == LPDP_RD1 && mem_cmd_valid && mem_cmd == `LPDP_CMD_READ;
    endproperty
    a_pair: assert property (p_pair) else $error("read pair broken");

    property p_act_first;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && st.inj == LPDP_IDLE && inj_due && !rd_pair && !mem_row_open)
        |=> st.inj == LPDP_ACT && mem_cmd_act;
    endproperty
    a_act_first: assert property (p_act_first) else $error("no activate");

    property p_restart;
        @(posedge sys_clk) disable iff (!rst_n)
        rd_pair |=> st.cnt == `LPDP_CNT_W'(`LPDP_PERIOD_CYC);
    endproperty
    a_restart: assert property (p_restart) else $error("interval not restarted");

    property p_lane0_map;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && mem_rd_valid && !mem_rd_injected)
        |=> app_rd_data[`LPDP_SLICE_W-1] == $past(mem_rd_beats[7*BW + 7]);
    endproperty
    a_lane0_map: assert property (p_lane0_map) else $error("beat order wrong");

    property p_wr_map;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && fifo_out_valid && fifo_out_ready)
        |=> memory_data_lines[(`LPDP_BEATS-1)*BW + `LPDP_LANE_W-1] ==
            $past(wr_word[`LPDP_SLICE_W-1]);
    endproperty
    a_wr_map: assert property (p_wr_map) else $error("write beat order wrong");

    property p_mask_map;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && fifo_out_valid && fifo_out_ready)
        |=> memory_mask_lines[`LPDP_BEATS*`LPDP_LANES-1] == $past(wr_mword[`LPDP_MASK_W-1]);
    endproperty
    a_mask_map: assert property (p_mask_map) else $error("mask beat order wrong");

    // Stalled beats must not be overwritten by the next FIFO word
    property p_wr_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && mem_wr_valid && !mem_wr_ready)
        |=> mem_wr_valid && $stable(memory_data_lines) && $stable(memory_mask_lines);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write beats dropped");

    property p_inj_next_addr;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.inj != LPDP_IDLE && app_en) |-> mem_cmd_addr == app_addr;
    endproperty
    a_inj_next_addr: assert property (p_inj_next_addr)
        else $error("injection address not next request");

    property p_inj_last_addr;
        @(posedge sys_clk) disable iff (!rst_n)
        (st.inj != LPDP_IDLE && !app_en) |-> mem_cmd_addr == st.last_addr;
    endproperty
    a_inj_last_addr: assert property (p_inj_last_addr)
        else $error("injection address not last one");

    sequence s_act_taken;
        clk_en && st.inj == LPDP_ACT && mem_cmd_ready;
    endsequence
    sequence s_rd1_taken;
        clk_en && st.inj == LPDP_RD1 && mem_cmd_ready;
    endsequence
    property p_act_then_rd;
        @(posedge sys_clk) disable iff (!rst_n)
        s_act_taken |=> st.inj == LPDP_RD0 && mem_cmd == `LPDP_CMD_READ;
    endproperty
    a_act_then_rd: assert property (p_act_then_rd)
        else $error("no read after activate");

    property p_pair_done;
        @(posedge sys_clk) disable iff (!rst_n)
        s_rd1_taken |=> st.inj == LPDP_IDLE && st.cnt == `LPDP_CNT_W'(`LPDP_PERIOD_CYC);
    endproperty
    a_pair_done: assert property (p_pair_done) else $error("pair did not restart");
endmodule // lpdp_datapath

// ==== design/lpdp_fifo.sv ====
// Write payload FIFO with valid and ready on both sides
`timescale 1ns/10ps
module lpdp_fifo #(
    parameter int WIDTH = 288,
    parameter int DEPTH = 16,
    parameter int PW = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } lpdp_fst_t;
    lpdp_fst_t st;
    lpdp_fst_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (st.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;
    assign out_data = mem[st.rp];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Storage needs no reset; count guards it
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end

    property p_no_overflow;
        @(posedge sys_clk) disable iff (!rst_n)
        st.cnt <= (PW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("fifo count exceeds depth");
endmodule // lpdp_fifo

// ==== design/lpdp_map.svh ====
// Constants for the user-side data path and periodic read injector
`ifndef LPDP_MAP_SVH
`define LPDP_MAP_SVH
`define LPDP_LANES 4
`define LPDP_BEATS 8
`define LPDP_LANE_W 8
`define LPDP_SLICE_W 64
`define LPDP_DATA_W 256
`define LPDP_MASK_W 32
`define LPDP_ADDR_W 28
`define LPDP_ROW_LSB 13
`define LPDP_ROW_W 15
`define LPDP_FIFO_DEPTH 16
`define LPDP_CMD_WRITE 3'h0
`define LPDP_CMD_READ 3'h1
`define LPDP_PERIOD_NS 1000
`define LPDP_CLK_PERIOD_NS 5
`define LPDP_PERIOD_CYC ((`LPDP_PERIOD_NS / `LPDP_CLK_PERIOD_NS) - 16)
`define LPDP_CNT_W 8
`define LPDP_RDQ_DEPTH 16
`define LPDP_RDQ_PW 4
`endif

// ==== design/lpdp_pkg.sv ====
// Types for the user-side data path
package lpdp_pkg;
    typedef enum logic [2:0] {
        LPDP_IDLE,
        LPDP_ACT,
        LPDP_RD0,
        LPDP_RD1
    } lpdp_inj_t;
endpackage

// ==== tb/lpdp_sched.sv ====
// Memory-side scheduler model for the data path
`timescale 1ns/10ps
`include "lpdp_map.svh"
module lpdp_sched (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stall_cmd,
    input wire logic stall_wr,
    input wire logic row_open,
    input wire logic user_rd,
    input wire logic mem_cmd_valid,
    input wire logic [2:0] mem_cmd,
    input wire logic mem_cmd_act,
    input wire logic [27:0] mem_cmd_addr,
    output logic mem_cmd_ready,
    output logic mem_row_open,
    input wire logic [255:0] memory_data_lines,
    input wire logic [31:0] memory_mask_lines,
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    output logic [255:0] mem_rd_beats,
    output logic mem_rd_valid,
    output logic mem_rd_injected,
    output logic [255:0] last_beats,
    output logic [31:0] last_mask,
    output logic [27:0] inj_addr,
    output int n_act,
    output int n_inj,
    output int n_wr
);
    logic [28:0] rq[$];
    int rt[$];
    logic [27:0] wq[$];
    logic [255:0] mem[logic [27:0]];
    int cyc;
    assign mem_cmd_ready = !stall_cmd;
    assign mem_wr_ready = !stall_wr;
    assign mem_row_open = row_open;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rq.delete();
            rt.delete();
            wq.delete();
            cyc <= 0;
            n_act <= 0;
            n_inj <= 0;
            n_wr <= 0;
            mem_rd_valid <= 1'b0;
            mem_rd_injected <= 1'b0;
            mem_rd_beats <= '0;
        end else begin
            cyc <= cyc + 1;
            // Idle beat and injected-flag lines toggle so stale data never looks steady; valid is held low
            mem_rd_valid <= 1'b0;
            mem_rd_injected <= ~mem_rd_injected;
            mem_rd_beats <= ~mem_rd_beats;
            if (mem_cmd_valid && mem_cmd_ready) begin
                if (mem_cmd_act) begin
                    n_act <= n_act + 1;
                end else if (mem_cmd == `LPDP_CMD_WRITE) begin
                    wq.push_back(mem_cmd_addr);
                end else begin
                    // A read not taken from the user is an injected one
                    rq.push_back({!user_rd, mem_cmd_addr});
                    rt.push_back(cyc + 4);
                    if (!user_rd) begin
                        n_inj <= n_inj + 1;
                        inj_addr <= mem_cmd_addr;
                    end
                end
            end
            if (mem_wr_valid && mem_wr_ready) begin
                n_wr <= n_wr + 1;
                last_beats <= memory_data_lines;
                last_mask <= memory_mask_lines;
                if (wq.size() > 0)
                    mem[wq.pop_front()] = memory_data_lines;
            end
            if (rq.size() > 0 && cyc >= rt[0]) begin
                mem_rd_valid <= 1'b1;
                mem_rd_injected <= rq[0][28];
                if (mem.exists(rq[0][27:0]))
                    mem_rd_beats <= mem[rq[0][27:0]];
                else
                    mem_rd_beats <= {8{4'h0, rq[0][27:0]}};
                void'(rq.pop_front());
                void'(rt.pop_front());
            end
        end
    end
endmodule // lpdp_sched

// ==== tb/tb.sv ====
// Self-checking bench for the user-side data path
`timescale 1ns/10ps
`include "lpdp_map.svh"
module tb;
    typedef struct {logic [27:0] a; logic [7:0] off; logic [31:0] m; logic [31:0] em;} lpdp_row_t;
    lpdp_row_t rows[4] = '{'{28'h0000100, 8'h00, 32'h0000000f, 32'h00001111},
        '{28'h0002040, 8'h5a, 32'h80000001, 32'h80000001},
        '{28'h1ffe000, 8'ha5, 32'h0f0ff0f0, 32'h3333cccc},
        '{28'hfffffc0, 8'hff, 32'hffffffff, 32'hffffffff}};
    logic sys_clk, rst_n, app_en, app_rdy, app_wdf_wren, app_wdf_end, app_wdf_rdy;
    logic app_rd_data_valid, app_rd_data_end, mem_cmd_valid, mem_cmd_act, mem_cmd_ready;
    logic mem_row_open, mem_wr_valid, mem_wr_ready, mem_rd_valid, mem_rd_injected;
    logic stall_cmd, stall_wr, row_open, user_rd, clk_en;
    logic [2:0] app_cmd, mem_cmd;
    logic [27:0] app_addr, mem_cmd_addr, inj_addr;
    logic [255:0] app_wdf_data, app_rd_data, memory_data_lines, mem_rd_beats, last_beats, rd0, rd1;
    logic [31:0] app_wdf_mask, memory_mask_lines, last_mask;
    int n_errors = 0, comparisons = 0, n_vld = 0, n_rd = 0, n_bad = 0;
    int n_act, n_inj, n_wr, i0, a0, cnt;
    assign user_rd = app_en && app_rdy && (app_cmd == `LPDP_CMD_READ);
    lpdp_datapath DUT (.sys_clk, .rst_n, .clk_en, .app_en, .app_cmd, .app_addr,
        .app_rdy, .app_wdf_data, .app_wdf_mask, .app_wdf_wren, .app_wdf_end, .app_wdf_rdy,
        .app_rd_data, .app_rd_data_valid, .app_rd_data_end, .mem_cmd_valid, .mem_cmd,
        .mem_cmd_act, .mem_cmd_addr, .mem_cmd_ready, .mem_row_open, .memory_data_lines,
        .memory_mask_lines, .mem_wr_valid, .mem_wr_ready, .mem_rd_beats, .mem_rd_valid,
        .mem_rd_injected);
    lpdp_sched model (.sys_clk, .rst_n, .stall_cmd, .stall_wr, .row_open, .user_rd,
        .mem_cmd_valid, .mem_cmd, .mem_cmd_act, .mem_cmd_addr, .mem_cmd_ready, .mem_row_open,
        .memory_data_lines, .memory_mask_lines, .mem_wr_valid, .mem_wr_ready, .mem_rd_beats,
        .mem_rd_valid, .mem_rd_injected, .last_beats, .last_mask, .inj_addr, .n_act, .n_inj,
        .n_wr);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [255:0] mk(input logic [7:0] off);
        logic [255:0] r;
        for (int b = 0; b < 32; b++)
            r[b*8+:8] = off + 8'(b * 7);
        return r;
    endfunction
    function automatic logic [255:0] to_beats(input logic [255:0] w);
        logic [255:0] r;
        for (int k = 0; k < 8; k++)
            for (int n = 0; n < 4; n++)
                r[k*32+n*8+:8] = w[n*64+k*8+:8];
        return r;
    endfunction
    // Payload rides with its command; each strobe drops once taken
    task automatic req(input logic [2:0] c, input logic [27:0] a, input logic [255:0] d,
                       input logic [31:0] m, input logic w);
        int n;
        logic en_t, wr_t;
        n = 0;
        @(negedge sys_clk);
        app_en = 1'b1;
        app_cmd = c;
        app_addr = a;
        app_wdf_data = d;
        app_wdf_mask = m;
        app_wdf_wren = w;
        app_wdf_end = w;
        if (c == `LPDP_CMD_READ)
            n_rd++;
        while ((app_en || app_wdf_wren) && n < 400) begin
            #1;
            en_t = app_en && app_rdy;
            wr_t = app_wdf_wren && app_wdf_rdy;
            @(negedge sys_clk);
            if (en_t)
                app_en = 1'b0;
            if (wr_t) begin
                app_wdf_wren = 1'b0;
                app_wdf_end = 1'b0;
            end
            n++;
        end
        check(n < 400, 1'b1);
    endtask
    task automatic get_rd(output logic [255:0] d);
        int n;
        n = 0;
        while (app_rd_data_valid !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(app_rd_data_end, 1'b1);
        d = app_rd_data;
        @(negedge sys_clk);
    endtask
    task automatic final_report();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Sampled mid-cycle, after inputs settle and before the edge
    always @(negedge sys_clk) begin
        #1;
        if (app_rd_data_valid === 1'b1)
            n_vld++;
        if (mem_cmd_valid && mem_cmd_ready && !user_rd && app_rdy &&
            (mem_cmd_act || mem_cmd == `LPDP_CMD_READ))
            n_bad++;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        check(1'b0, 1'b1);
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        app_en = 1'b0;
        app_cmd = 3'h0;
        app_addr = '0;
        app_wdf_data = '0;
        app_wdf_mask = '0;
        app_wdf_wren = 1'b0;
        app_wdf_end = 1'b0;
        stall_cmd = 1'b0;
        stall_wr = 1'b0;
        clk_en = 1'b1;
        row_open = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            req(`LPDP_CMD_WRITE, rows[i].a, mk(rows[i].off), rows[i].m, 1'b1);
            req(`LPDP_CMD_READ, rows[i].a, '0, '0, 1'b0);
            get_rd(rd0);
            check(rd0, mk(rows[i].off));
            check(last_beats, to_beats(mk(rows[i].off)));
            check(last_mask, rows[i].em);
        end
        $display("done: lane map rows");
        req(`LPDP_CMD_READ, rows[0].a, '0, '0, 1'b0);
        req(`LPDP_CMD_READ, rows[2].a, '0, '0, 1'b0);
        get_rd(rd0);
        get_rd(rd1);
        check(rd0, mk(rows[0].off));
        check(rd1, mk(rows[2].off));
        $display("done: read order");
        row_open = 1'b0;
        i0 = n_inj;
        a0 = n_act;
        cnt = 0;
        while (n_inj < i0 + 2 && cnt < 400) begin
            @(negedge sys_clk);
            cnt++;
        end
        check(n_inj - i0, 2);
        check(inj_addr, rows[2].a);
        check(n_act - a0, 1);
        row_open = 1'b1;
        $display("done: idle injection");
        // Held write meets a due injection while the far side stalls
        stall_cmd = 1'b1;
        i0 = n_inj;
        fork
            begin
                repeat (200) @(negedge sys_clk);
                stall_cmd = 1'b0;
            end
        join_none
        req(`LPDP_CMD_WRITE, 28'h0abc040, mk(8'h33), '0, 1'b1);
        check(n_inj - i0, 2);
        check(inj_addr, 28'h0abc040);
        check(n_bad, 0);
        $display("done: busy injection");
        rst_n = 1'b0;
        #1;
        check(app_rd_data_valid, 1'b0);
        check(app_wdf_rdy, 1'b1);
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        req(`LPDP_CMD_WRITE, rows[1].a, mk(8'h77), '0, 1'b1);
        req(`LPDP_CMD_READ, rows[1].a, '0, '0, 1'b0);
        get_rd(rd0);
        check(rd0, mk(8'h77));
        $display("done: mid-run reset");
        // Frozen enable: interval must not expire, buffer must not fill
        i0 = n_inj;
        a0 = n_wr;
        clk_en = 1'b0;
        app_wdf_wren = 1'b1;
        repeat (200) @(negedge sys_clk);
        check(n_inj - i0, 0);
        check(n_wr - a0, 0);
        check(app_wdf_rdy, 1'b1);
        app_wdf_wren = 1'b0;
        clk_en = 1'b1;
        $display("done: clock enable freeze");
        stall_wr = 1'b1;
        cnt = 0;
        i0 = n_wr;
        app_wdf_wren = 1'b1;
        repeat (24) begin
            #1;
            if (app_wdf_rdy)
                cnt++;
            @(negedge sys_clk);
        end
        check(app_wdf_rdy, 1'b0);
        app_wdf_wren = 1'b0;
        stall_wr = 1'b0;
        repeat (40) @(negedge sys_clk);
        check(cnt >= 16 && cnt <= 17, 1'b1);
        check(n_wr - i0, cnt);
        check(app_wdf_rdy, 1'b1);
        check(n_vld, n_rd);
        $display("done: buffer fill");
        final_report();
    end
endmodule // tb
